// *** core/itic_core.sv ***
// Operation
// - Count register, two prescale stages, counter, toggle.
// - Tick every 8 us or 128 us.
// - Interval spans 8us-2ms or 128us-32ms.
// - Count write restarts prescalers, toggle, counter.
// - Comparator match is the timer request.
// - Match clears counter; counting resumes.
// - Toggle flips per match, drives square wave.
// - Unmasked timer match ends halt state.
// - Timer mask bit one blocks timer.
// - Mode bits: wave enable, prescale insert.
// - Mode moves use accumulator bits 0-2.
// - Vectors 4, 8, 16 by priority.
// - Highest priority unmasked request is accepted.
// - Level flag follows its pin.
// - Rising edge sets edge flag.
// - Match pulse sets timer flag.
// - Reset or STOP clears all flags.
// - Serial-done flag sets, never interrupts.
// - Global enable: set, clear, accept, reset.
// - Sample requests at first machine cycle.
// - Acknowledge clears flag, except level source.
// - Reset loads count all ones, clears counters.
module itic_core #(
   parameter int BASE_DIV = itic_pkg::BASE_CYCLES
) (
   // Clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_n_i,
   // Core register writes and reads
   input  wire logic                        count_we_i,
   input  wire logic                        mode_we_i,
   input  wire logic                        mask_we_i,
   input  wire logic [7:0]                  acc_i,
   output logic [7:0]                       count_o,
   output logic [itic_pkg::MODE_W-1:0]      timer_mode_o,
   output logic [itic_pkg::MASK_W-1:0]      interrupt_mask_o,
   // Sequencer control
   input  wire logic                        global_irq_on_instr_i,
   input  wire logic                        global_irq_off_instr_i,
   input  wire logic                        first_cycle_i,
   input  wire logic                        ack_i,
   input  wire logic                        stop_mode_i,
   input  wire logic                        halt_mode_i,
   input  wire logic                        serial_done_i,
   input  wire logic                        skip_if_flag_clear_i,
   // External request pins
   input  wire logic                        level_request_in_i,
   input  wire logic                        edge_request_in_i,
   // Interrupt answer
   output logic                             irq_req_o,
   output logic [7:0]                       irq_vector_o,
   output logic                             global_irq_enable_o,
   output logic [3:0]                       flags_o,
   output logic                             halt_release_o,
   // Timer outputs
   output logic                             timer_match_request_o,
   output logic                             square_wave_pin_o
);
   import itic_pkg::*;

   // -----------------------------------------------------------------
   // Elaboration checks
   // -----------------------------------------------------------------
   // The base counter is 8 bits wide, so a longer divider could never reach its step.
   if (BASE_DIV < 1 || BASE_DIV > 255)
   begin : g_bad_base_div
      $error("itic_core: BASE_DIV out of range.");
   end

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   // Every flop of the block outside the two prescale stages sits in this one struct, so one reset covers all of it.
   typedef struct packed {
      logic [BASE_W-1:0] base;            // Base divider of the system clock.
      logic [7:0]        count;           // Programmed interval.
      logic [7:0]        tick;            // Tick counter.
      logic [2:0]        mode;            // Timer mode bits.
      logic [2:0]        mask;            // Interrupt mask.
      logic              toggle;          // Square wave toggle.
      logic              level_flag;      // Level request flag.
      logic              edge_flag;       // Edge request flag.
      logic              timer_flag;      // Timer request flag.
      logic              serial_flag;     // Serial-done flag.
      logic              edge_prev;       // Previous edge pin level.
      logic              gie;             // Global interrupt enable.
      logic              pend;            // Request sampled in first cycle.
      logic [7:0]        vector;          // Vector of the sampled request.
   } itic_state_t;

   itic_state_t st;
   itic_state_t next_st;

   logic        base_step;   // One-cycle enable every BASE_DIV cycles.
   logic        carry_a;     // Carry of the first stage.
   logic        carry_b;     // Carry of the second stage.
   logic        b_step;      // Step of the second stage.
   logic        tick_step;   // Tick counter enable.
   logic        match;       // Comparator match pulse.
   logic        restart;     // Counter chain clear.
   logic [2:0]  req;         // Unmasked requests, level/timer/edge.

   // Chain restarts on a count write or in STOP mode.
   assign restart   = count_we_i || stop_mode_i;
   // Base step: a one-cycle enable at the end of each BASE_DIV count.
   assign base_step = (st.base == BASE_W'(BASE_DIV - 1));
   // With tick select set, the first stage sits in the chain: 8 us x 16.
   assign b_step    = st.mode[MODE_TICK_SEL] ? carry_a : base_step;
   assign tick_step = carry_b;

   // -----------------------------------------------------------------
   // Prescale stages
   // -----------------------------------------------------------------
   itic_prescale #(.WIDTH(4)) u_prescale_stage_a (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .clear_i (restart),
      .step_i  (base_step && st.mode[MODE_TICK_SEL]),
      .carry_o (carry_a)
   );

   itic_prescale #(.WIDTH(3)) u_prescale_stage_b (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .clear_i (restart),
      .step_i  (b_step),
      .carry_o (carry_b)
   );

   // Comparator: the counter runs from 0 and is compared plus one, so a count of N gives N ticks.
   // The look-ahead compare clears the counter in the match cycle and saves a step of latency.
   // A restart in the same cycle suppresses the match, so a new count never fires on the old chain.
   assign match = !restart && tick_step && ((st.tick + 8'h01) == st.count);

   // Unmasked requests in priority order.
   // A mask bit of one removes its source before priority is resolved.
   assign req[0] = st.level_flag && !st.mask[MASK_LEVEL];
   assign req[1] = st.timer_flag && !st.mask[MASK_TIMER];
   assign req[2] = st.edge_flag  && !st.mask[MASK_EDGE];

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      // Base divider; cleared with the chain so the first tick is whole.
      if (restart || base_step)
      begin
         next_st.base = '0;
      end
      else
      begin
         next_st.base = st.base + 1'b1;
      end
      // Tick counter and toggle.
      if (restart)
      begin
         next_st.tick   = 8'h00;
         next_st.toggle = 1'b0;
      end
      else if (match)
      begin
         next_st.tick   = 8'h00;
         next_st.toggle = !st.toggle;
      end
      else if (tick_step)
      begin
         next_st.tick = st.tick + 8'h01;
      end
      if (count_we_i)
      begin
         next_st.count = acc_i;
      end
      if (mode_we_i)
      begin
         next_st.mode = acc_i[MODE_W-1:0];
      end
      if (mask_we_i)
      begin
         next_st.mask = acc_i[MASK_W-1:0];
      end
      // Level flag is a plain follower of the pin.
      next_st.level_flag = level_request_in_i;
      // The previous level starts low, so a pin that is high when reset ends counts as an edge.
      next_st.edge_prev  = edge_request_in_i;
      // Acknowledge clears first; a new event in the same cycle sets again.
      if (ack_i && st.pend && st.vector == VEC_EDGE)
      begin
         next_st.edge_flag = 1'b0;
      end
      if (ack_i && st.pend && st.vector == VEC_TIMER)
      begin
         next_st.timer_flag = 1'b0;
      end
      if (edge_request_in_i && !st.edge_prev)
      begin
         next_st.edge_flag = 1'b1;
      end
      if (match)
      begin
         next_st.timer_flag = 1'b1;
      end
      // Test instruction consumes the serial flag unless it sets again.
      // The serial flag never feeds the request vector; only the test instruction reads it.
      if (skip_if_flag_clear_i)
      begin
         next_st.serial_flag = 1'b0;
      end
      if (serial_done_i)
      begin
         next_st.serial_flag = 1'b1;
      end
      // Global enable; the off instruction overrides the on one.
      // An accept in the same cycle as the on instruction still clears the enable.
      if (global_irq_on_instr_i)
      begin
         next_st.gie = 1'b1;
      end
      if (global_irq_off_instr_i || (ack_i && st.pend))
      begin
         next_st.gie = 1'b0;
      end
      // Sample requests once per instruction.
      // Pending then holds until the accept, STOP or the next first cycle; the vector holds until the next first cycle.
      if (first_cycle_i)
      begin
         next_st.pend = st.gie && (req != 3'h0);
         if (req[0])
         begin
            next_st.vector = VEC_LEVEL;
         end
         else if (req[1])
         begin
            next_st.vector = VEC_TIMER;
         end
         else if (req[2])
         begin
            next_st.vector = VEC_EDGE;
         end
         else
         begin
            next_st.vector = VEC_NONE;
         end
      end
      else if (ack_i)
      begin
         next_st.pend = 1'b0;
      end
      // STOP clears flags, enable, mask is set and tick select set.
      // Square-wave enable bits survive STOP; only the tick select is forced.
      if (stop_mode_i)
      begin
         next_st.level_flag  = 1'b0;
         next_st.edge_flag   = 1'b0;
         next_st.timer_flag  = 1'b0;
         next_st.serial_flag = 1'b0;
         next_st.gie         = 1'b0;
         next_st.pend        = 1'b0;
         next_st.mask        = MASK_RESET;
         next_st.count       = COUNT_RESET;
         next_st.mode[MODE_TICK_SEL] = 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   // Synchronous reset; fields not loaded below start at zero, which is their idle value.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         st        <= '0;
         st.count  <= COUNT_RESET;
         st.mode   <= MODE_RESET;
         st.mask   <= MASK_RESET;
         st.vector <= VEC_NONE;
      end
      else
      begin
         st <= next_st;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // Register views are plain copies of the state, so reading them has no side effect.
   assign count_o               = st.count;
   assign timer_mode_o          = st.mode;
   assign interrupt_mask_o      = st.mask;
   assign irq_req_o             = st.pend;
   assign irq_vector_o          = st.vector;
   assign global_irq_enable_o   = st.gie;
   assign flags_o               = {st.serial_flag, st.timer_flag, st.edge_flag, st.level_flag};
   assign timer_match_request_o = match;
   // Halt ends on a match; the mask still chooses wake sources.
   // The release is a combinational pulse, so the core can restart in the match cycle.
   assign halt_release_o        = halt_mode_i && match && !st.mask[MASK_TIMER];
   // Both enable bits must be clear for the wave to reach the pin.
   assign square_wave_pin_o     = st.toggle && !st.mode[MODE_SQW_LO] && !st.mode[MODE_SQW_HI];
endmodule : itic_core

// *** core/itic_pkg.sv ***
package itic_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int          CLK_HZ           = 40_000_000;  // System clock rate.
   localparam int          TICK_FAST_NS     = 8_000;       // Tick period with tick select 0.
   localparam int          TICK_SLOW_NS     = 128_000;     // Tick period with tick select 1.
   localparam int          STAGE_B_STEPS    = 8;           // Wraps of the 3-bit second stage.
   localparam int          STAGE_A_STEPS    = 16;          // Wraps of the 4-bit first stage.
   // Base cycles per step of the second stage: 8 us / 8 steps.
   localparam int          BASE_CYCLES      = (TICK_FAST_NS / STAGE_B_STEPS) / (1_000_000_000 / CLK_HZ);
   localparam int          BASE_W           = 8;           // Width of the base divider.

   // -----------------------------------------------------------------
   // Field layouts and reset values
   // -----------------------------------------------------------------
   localparam int          MODE_W           = 3;           // Timer mode register width.
   localparam int          MASK_W           = 3;           // Interrupt mask width.
   localparam int          MODE_SQW_LO      = 0;           // Square wave enable, low bit.
   localparam int          MODE_SQW_HI      = 1;           // Square wave enable, high bit.
   localparam int          MODE_TICK_SEL    = 2;           // Tick select bit.
   localparam int          MASK_LEVEL       = 0;           // Mask bit of the level source.
   localparam int          MASK_TIMER       = 1;           // Mask bit of the timer source.
   localparam int          MASK_EDGE        = 2;           // Mask bit of the edge source.
   localparam logic [7:0]  COUNT_RESET      = 8'hFF;       // Count register after reset.
   localparam logic [2:0]  MODE_RESET       = 3'h7;        // Timer mode after reset.
   localparam logic [2:0]  MASK_RESET       = 3'h7;        // Mask after reset.

   // -----------------------------------------------------------------
   // Vectors
   // -----------------------------------------------------------------
   localparam logic [7:0]  VEC_LEVEL        = 8'h04;       // Level request start address.
   localparam logic [7:0]  VEC_TIMER        = 8'h08;       // Timer request start address.
   localparam logic [7:0]  VEC_EDGE         = 8'h10;       // Edge request start address.
   localparam logic [7:0]  VEC_NONE         = 8'h00;       // No request accepted.
endpackage : itic_pkg

// *** core/itic_prescale.sv ***
// One wrapping counter stage; emits a carry when it wraps on an enable.
module itic_prescale #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   // Control
   input  wire logic             clear_i,
   input  wire logic             step_i,
   // Result
   output logic                  carry_o
);
   import itic_pkg::*;

   // Refused at elaboration, since a stage wider than 16 bits is never needed here.
   if (WIDTH < 1 || WIDTH > 16)
   begin : g_bad_width
      $error("itic_prescale: WIDTH out of range.");
   end

   typedef struct packed {
      logic [WIDTH-1:0] count;   // Stage count.
   } itic_pre_state_t;

   itic_pre_state_t st;
   itic_pre_state_t next_st;

   // Carry is combinational so that the next stage steps in the same cycle.
   assign carry_o = step_i && (st.count == {WIDTH{1'b1}});

   // Next state: clear wins over stepping.
   always_comb
   begin
      next_st = st;
      if (clear_i)
      begin
         next_st.count = '0;
      end
      else if (step_i)
      begin
         next_st.count = st.count + 1'b1;
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end
endmodule : itic_prescale

// *** test/itic_core_monitor.sv ***
module itic_core_monitor #(
   parameter int BASE_DIV = itic_pkg::BASE_CYCLES
) (
   // Clock and reset
   input wire logic                        clk_i,
   input wire logic                        rst_n_i,
   // Design inputs
   input wire logic                        count_we_i,
   input wire logic                        mode_we_i,
   input wire logic                        first_cycle_i,
   input wire logic                        ack_i,
   input wire logic                        stop_mode_i,
   input wire logic                        global_irq_on_instr_i,
   input wire logic                        level_request_in_i,
   // Design outputs
   input wire logic [7:0]                  count_o,
   input wire logic [itic_pkg::MODE_W-1:0] timer_mode_o,
   input wire logic [itic_pkg::MASK_W-1:0] interrupt_mask_o,
   input wire logic                        irq_req_o,
   input wire logic [7:0]                  irq_vector_o,
   input wire logic                        global_irq_enable_o,
   input wire logic [3:0]                  flags_o,
   input wire logic                        timer_match_request_o,
   input wire logic                        square_wave_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import itic_pkg::*;
   // -----------------------------------------------------------------
   // Interval gauge
   // -----------------------------------------------------------------
   logic [20:0] gap;   // Cycles since the last match; 21 bits hold a slow 256-step interval.
   logic        whole; // The gap spans a full interval.
   int          tick;  // Cycles per counter step.
   assign tick = STAGE_B_STEPS * BASE_DIV * (timer_mode_o[MODE_TICK_SEL] ? STAGE_A_STEPS : 1);
   // A count or mode write or STOP retimes the chain, so the next gap is not whole.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || count_we_i || mode_we_i || stop_mode_i)
      begin
         gap   <= 21'h000001;
         whole <= 1'b0;
      end
      else
      begin
         gap   <= timer_match_request_o ? 21'h000001 : gap + 21'h000001;
         whole <= whole | timer_match_request_o;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   property p_interval;
      timer_match_request_o && whole |-> gap == ((count_o == 8'h00) ? 256 : count_o) * tick;
   endproperty
   a_interval: assert property (p_interval) else $error("Match interval wrong.");
   property p_flag;
      timer_match_request_o && !stop_mode_i |=> flags_o[2];
   endproperty
   a_flag: assert property (p_flag) else $error("Timer flag not set.");
   property p_toggle;
      timer_match_request_o && timer_mode_o[1:0] == 2'h0 && !count_we_i && !mode_we_i && !stop_mode_i
         |=> square_wave_pin_o != $past(square_wave_pin_o);
   endproperty
   a_toggle: assert property (p_toggle) else $error("Pin did not toggle.");
   property p_pin_low;
      timer_mode_o[1:0] != 2'h0 |-> !square_wave_pin_o;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("Disabled pin not low.");
   property p_level;
      (rst_n_i && !stop_mode_i && level_request_in_i) [*2] |-> flags_o[0];
   endproperty
   a_level: assert property (p_level) else $error("Level flag lost.");
   property p_accept;
      first_cycle_i && global_irq_enable_o && flags_o[0] && !interrupt_mask_o[0] && !stop_mode_i
         |=> irq_req_o && irq_vector_o == VEC_LEVEL;
   endproperty
   a_accept: assert property (p_accept) else $error("Level request not taken.");
   property p_quiet;
      first_cycle_i && !global_irq_on_instr_i
         && (!global_irq_enable_o || ({flags_o[1], flags_o[2], flags_o[0]} & ~interrupt_mask_o) == 3'h0)
         |=> !irq_req_o;
   endproperty
   a_quiet: assert property (p_quiet) else $error("Request without cause.");
   property p_ack;
      irq_req_o && ack_i && !global_irq_on_instr_i && !first_cycle_i |=> !global_irq_enable_o && !irq_req_o;
   endproperty
   a_ack: assert property (p_ack) else $error("Accept left enable set.");
   property p_stop;
      stop_mode_i && !count_we_i |=> flags_o == 4'h0 && !global_irq_enable_o
         && interrupt_mask_o == MASK_RESET && count_o == COUNT_RESET && timer_mode_o[MODE_TICK_SEL];
   endproperty
   a_stop: assert property (p_stop) else $error("STOP left state.");
   c_match: cover property (timer_match_request_o && whole);
   c_take: cover property (irq_req_o && ack_i);
   c_stop: cover property (stop_mode_i);
endmodule : itic_core_monitor

bind itic_core itic_core_monitor #(.BASE_DIV(BASE_DIV)) u_mon (.clk_i, .rst_n_i, .count_we_i, .mode_we_i,
   .first_cycle_i, .ack_i, .stop_mode_i, .global_irq_on_instr_i, .level_request_in_i, .count_o,
   .timer_mode_o, .interrupt_mask_o, .irq_req_o, .irq_vector_o, .global_irq_enable_o, .flags_o,
   .timer_match_request_o, .square_wave_pin_o);

// *** test/itic_seq_model.sv ***
// Sequencer stand-in: one first cycle per four-cycle instruction, and an
// accept in the cycle that shows a request.
module itic_seq_model (
   // Clock and control
   input  wire logic       clk_i,
   input  wire logic       run_i,
   // Controller answer
   input  wire logic       irq_req_i,
   input  wire logic [7:0] irq_vector_i,
   // Sequencer strobes and record
   output logic            first_cycle_o,
   output logic            ack_o,
   output logic [7:0]      vector_o,
   output logic [7:0]      acks_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase = 2'h0; // Machine cycle within an instruction.
   initial
   begin
      first_cycle_o = 1'b0;
      ack_o         = 1'b0;
      vector_o      = 8'h00;
      acks_o        = 8'h00;
   end
   // Strobes move on the falling edge, clear of the sampling edge.
   always @(negedge clk_i)
   begin
      first_cycle_o <= 1'b0;
      ack_o         <= 1'b0;
      phase         <= phase + 2'h1;
      if (run_i && irq_req_i && !ack_o)
      begin
         ack_o    <= 1'b1;
         vector_o <= irq_vector_i;
         acks_o   <= acks_o + 8'h01;
      end
      else if (run_i && phase == 2'h0)
         first_cycle_o <= 1'b1;
   end
endmodule : itic_seq_model

// *** test/tb_interval_timer_interrupt_ctrl.sv ***
module tb_interval_timer_interrupt_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import itic_pkg::*;
   localparam int TICK = STAGE_B_STEPS * 2; // Fast step with a base divider of 2.
   typedef struct {logic [7:0] cnt; logic [2:0] mode; int gap; logic tog;} itic_row_t;
   itic_row_t rows[6] = '{'{8'h01, 3'h0, TICK, 1}, '{8'h03, 3'h0, 3 * TICK, 1}, '{8'h00, 3'h0, 256 * TICK, 1},
      '{8'hFF, 3'h1, 255 * TICK, 0}, '{8'h02, 3'h4, 32 * TICK, 1}, '{8'h01, 3'h6, 16 * TICK, 0}};
   logic [7:0] vecs[3] = '{VEC_LEVEL, VEC_TIMER, VEC_EDGE};
   logic clk_i = 0, rst_n_i = 0, count_we_i = 0, mode_we_i = 0, mask_we_i = 0, stop_mode_i = 0, run = 0;
   logic global_irq_on_instr_i = 0, global_irq_off_instr_i = 0, halt_mode_i = 1, serial_done_i = 0;
   logic skip_if_flag_clear_i = 0, level_request_in_i = 0, edge_request_in_i = 0, p;
   logic [7:0] acc_i = 0, count_o, irq_vector_o, vec, acks, k;
   logic [2:0] timer_mode_o, interrupt_mask_o;
   logic [3:0] flags_o;
   logic first_cycle_i, ack_i, irq_req_o, global_irq_enable_o, halt_release_o, timer_match_request_o;
   logic square_wave_pin_o;
   int errors = 0, tests_run = 0, n;
   itic_core #(.BASE_DIV(2)) dut (.clk_i, .rst_n_i, .count_we_i, .mode_we_i, .mask_we_i, .acc_i, .count_o,
      .timer_mode_o, .interrupt_mask_o, .global_irq_on_instr_i, .global_irq_off_instr_i, .first_cycle_i,
      .ack_i, .stop_mode_i, .halt_mode_i, .serial_done_i, .skip_if_flag_clear_i, .level_request_in_i,
      .edge_request_in_i, .irq_req_o, .irq_vector_o, .global_irq_enable_o, .flags_o, .halt_release_o,
      .timer_match_request_o, .square_wave_pin_o);
   itic_seq_model seq (.clk_i, .run_i(run), .irq_req_i(irq_req_o), .irq_vector_i(irq_vector_o),
      .first_cycle_o(first_cycle_i), .ack_o(ack_i), .vector_o(vec), .acks_o(acks));
   always #12.5 clk_i = ~clk_i;
   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : check
   // One-cycle strobe with write data, launched on the falling edge.
   task automatic wr(ref logic we, input logic [7:0] v);
      @(negedge clk_i);
      acc_i = v;
      we = 1'b1;
      @(negedge clk_i);
      we = 1'b0;
   endtask : wr
   // Counts cycles to the next match; halt is held so release is seen too.
   task automatic wait_match();
      n = 0;
      do
      begin
         @(negedge clk_i);
         n++;
      end
      while (timer_match_request_o !== 1'b1 && n < 20000);
      check(32'(halt_release_o), 32'(!interrupt_mask_o[MASK_TIMER]), "halt release");
      if (n >= 20000)
      begin
         errors++;
         report_and_stop();
      end
   endtask : wait_match
   initial
   begin
      #2_000_000;
      errors++;
      report_and_stop();
   end
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial
   begin
      repeat (10) @(negedge clk_i);
      rst_n_i = 1;
      foreach (rows[i])
      begin
         wr(mode_we_i, 8'(rows[i].mode));
         wr(count_we_i, rows[i].cnt);
         wait_match();
         check(32'(n), 32'(rows[i].gap - 1), "restart");
         wait_match();
         // Pin level just before the flip that this match causes.
         p = square_wave_pin_o;
         check(32'(n), 32'(rows[i].gap), "interval");
         @(negedge clk_i);
         check(32'(square_wave_pin_o), 32'(rows[i].tog ? !p : 1'b0), "pin");
      end
      rst_n_i = 0;
      repeat (2) @(negedge clk_i);
      rst_n_i = 1;
      check({count_o, timer_mode_o, interrupt_mask_o, flags_o, global_irq_enable_o, square_wave_pin_o,
         irq_req_o, irq_vector_o}, {COUNT_RESET, MODE_RESET, MASK_RESET, 4'h0, 3'h0, VEC_NONE}, "reset");
      wr(mode_we_i, 8'hFB);
      wr(mask_we_i, 8'hFA);
      check({timer_mode_o, interrupt_mask_o}, 32'h1A, "mode and mask");
      wr(global_irq_on_instr_i, 8'h00);
      check(32'(global_irq_enable_o), 32'h1, "enable on");
      wr(global_irq_off_instr_i, 8'h00);
      check(32'(global_irq_enable_o), 32'h0, "enable off");
      wr(count_we_i, 8'h01);
      level_request_in_i = 1;
      edge_request_in_i = 1;
      wait_match();
      wr(mask_we_i, 8'h00);
      wait_match();
      // A long interval keeps the timer flag from coming back inside the accept tests.
      wr(count_we_i, 8'h00);
      run = 1;
      foreach (vecs[i])
      begin
         wr(global_irq_on_instr_i, 8'h00);
         k = acks;
         for (n = 0; n < 40 && acks === k; n++)
            @(negedge clk_i);
         check(32'(vec), 32'(vecs[i]), "vector");
         check(32'(global_irq_enable_o), 32'h0, "enable after accept");
         check(32'(flags_o[i == 0 ? 0 : 3 - i]), 32'(i == 0), "flag after accept");
         level_request_in_i = 0;
         wr(mask_we_i, 8'h01);
      end
      // Enabled and sampled, yet the serial flag alone must raise no request.
      wr(global_irq_on_instr_i, 8'h00);
      wr(serial_done_i, 8'h00);
      repeat (8) @(negedge clk_i);
      check({flags_o[3], irq_req_o}, 32'h2, "serial done");
      run = 0;
      wr(skip_if_flag_clear_i, 8'h00);
      check(32'(flags_o[3]), 32'h0, "serial test");
      edge_request_in_i = 0;
      wr(global_irq_on_instr_i, 8'h00);
      edge_request_in_i = 1;
      wr(stop_mode_i, 8'h00);
      check({flags_o, global_irq_enable_o, interrupt_mask_o, count_o}, {8'h07, COUNT_RESET}, "stop");
      report_and_stop();
   end
endmodule : tb_interval_timer_interrupt_ctrl
